//--- verilog/sleep_clk_ctrl.sv
// sleep-mode clock domain control, peripheral clock stop and analog helper enables
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
module sleep_clk_ctrl #(
	parameter int STARTUP_CYC = 16,
	parameter int REF_START_CYC = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [sleep_clk_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_sleep_exec,
	input wire sleep_clk_pkg::wake_t i_wake,
	input wire logic i_crystal_sel,
	input wire logic [2:0] i_bod_fuses,
	input wire logic i_wdt_en,
	input wire logic i_conv_start,
	output sleep_clk_pkg::clk_dom_t o_dom,
	output logic [sleep_clk_pkg::NPER-1:0] o_periph_clk_en,
	output logic [sleep_clk_pkg::NPER-1:0] o_periph_access_en,
	output logic o_comp_mux_allow,
	output logic o_comp_active,
	output logic o_conv_en,
	output logic o_conv_extended,
	output logic o_ref_en,
	output logic o_ref_ready,
	output logic o_bod_en,
	output logic o_wdt_run
);
	import sleep_clk_pkg::*;

	// standby without a crystal falls back to power-down (oscillator not kept)
	function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic xtal);
		eff_mode = (m == MODE_STANDBY && !xtal) ? MODE_PDOWN : m;
	endfunction

	function automatic logic mode_valid(input logic [2:0] m);
		mode_valid = (m == MODE_IDLE) || (m == MODE_NOISE) ||
			(m == MODE_PDOWN) || (m == MODE_STANDBY);
	endfunction

	function automatic clk_dom_t dom_for(input state_t s, input logic [2:0] m);
		clk_dom_t d;
		d = '{default: 1'b1};
		if (s == S_SLEEP || s == S_WAKE) begin
			d.cpu = 1'b0;
			d.flash = 1'b0;
			case (m)
				MODE_IDLE: d = d;
				MODE_NOISE: d.io = 1'b0;
				MODE_STANDBY: begin
					d.io = 1'b0;
					d.conv = 1'b0;
					d.pll = 1'b0;
				end
				default: begin
					d.io = 1'b0;
					d.conv = 1'b0;
					d.pll = 1'b0;
					d.main_src = 1'b0;
				end
			endcase
		end
		dom_for = d;
	endfunction

	function automatic logic wake_hit(input logic [2:0] m, input wake_t w);
		case (m)
			MODE_IDLE: wake_hit = |w;
			MODE_NOISE: wake_hit = w.ext_level | w.power_stage_controller | w.store_ready |
				w.conv | w.wdt;
			default: wake_hit = w.ext_level | w.wdt;
		endcase
	endfunction

	// register bus group
	logic [7:0] stop_q, stop_d;
	logic [2:0] mode_q, mode_d;
	logic sleep_en_q, sleep_en_d;
	logic [2:0] analog_q, analog_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	state_t state_q, state_d;
	logic [2:0] sleep_mode_q, sleep_mode_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ext_q, ext_d;
	logic [CNT_W-1:0] ref_cnt_q, ref_cnt_d;
	logic ref_ready_q, ref_ready_d;
	logic ref_en_q, ref_en_d;
	logic req;

	assign req = (i_avs_read | i_avs_write) & !ack_q;

	always_comb begin
		stop_d = stop_q;
		mode_d = mode_q;
		sleep_en_d = sleep_en_q;
		analog_d = analog_q;
		rdata_d = rdata_q;
		ack_d = req;
		// write lands on the edge where the master sees waitrequest low
		if (ack_q && i_avs_write && i_avs_byteenable[0]) begin
			case (i_avs_address)
				// bit 7 never stored, so it reads zero
				OFF_CLK_STOP: stop_d = {1'b0, i_avs_writedata[6:0]};
				OFF_SLEEP_CTRL: begin
					mode_d = i_avs_writedata[MODE_LSB+2:MODE_LSB];
					sleep_en_d = i_avs_writedata[SLEEP_EN_BIT];
				end
				OFF_ANALOG: analog_d = i_avs_writedata[2:0];
				default: stop_d = stop_q;
			endcase
		end
		if (req && i_avs_read) begin
			case (i_avs_address)
				OFF_CLK_STOP: rdata_d = {24'h000000, stop_q};
				OFF_SLEEP_CTRL: rdata_d = {28'h0000000, mode_q, sleep_en_q};
				OFF_STATUS: rdata_d = {26'h0, ext_q, ref_ready_q, ref_en_q,
					sleep_mode_q == MODE_STANDBY, state_q};
				OFF_ANALOG: rdata_d = {29'h0, analog_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			stop_q <= CLK_STOP_RESET;
			mode_q <= MODE_IDLE;
			sleep_en_q <= 1'b0;
			analog_q <= 3'h0;
			ack_q <= 1'b0;
			o_avs_waitrequest <= 1'b1;
			rdata_q <= 32'h00000000;
		end else begin
			stop_q <= stop_d;
			mode_q <= mode_d;
			sleep_en_q <= sleep_en_d;
			analog_q <= analog_d;
			ack_q <= ack_d;
			o_avs_waitrequest <= !ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_avs_readdata = rdata_q;

	// sleep sequencer group
	always_comb begin
		state_d = state_q;
		sleep_mode_d = sleep_mode_q;
		cnt_d = cnt_q;
		case (state_q)
			S_ACTIVE: begin
				// reserved codes leave the core running
				if (i_sleep_exec && sleep_en_q && mode_valid(mode_q)) begin
					state_d = S_SLEEP;
					sleep_mode_d = eff_mode(mode_q, i_crystal_sel);
				end
			end
			S_SLEEP: begin
				if (wake_hit(sleep_mode_q, i_wake)) begin
					state_d = S_WAKE;
					if (sleep_mode_q == MODE_STANDBY) begin
						cnt_d = STANDBY_WAKE_CYC - 16'h0001;
					end else if (sleep_mode_q == MODE_PDOWN) begin
						cnt_d = CNT_W'(STARTUP_CYC) + WAKE_HALT_CYC - 16'h0001;
					end else begin
						cnt_d = WAKE_HALT_CYC - 16'h0001;
					end
				end
			end
			S_WAKE: begin
				if (cnt_q == '0) begin
					state_d = S_ACTIVE;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			default: state_d = S_ACTIVE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= S_ACTIVE;
			sleep_mode_q <= MODE_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			sleep_mode_q <= sleep_mode_d;
			cnt_q <= cnt_d;
		end
	end

	// analog helper group
	clk_dom_t dom_d;
	logic [NPER-1:0] pclk_d;
	logic deep_d, comp_act_d, ref_need;

	assign dom_d = dom_for(state_d, sleep_mode_d);
	assign deep_d = (state_d != S_ACTIVE) && (sleep_mode_d != MODE_IDLE) &&
		(sleep_mode_d != MODE_NOISE);
	assign comp_act_d = analog_q[AN_COMP_EN] && !deep_d;
	// comparator on the reference holds it on even in deep sleep
	assign ref_need = (i_bod_fuses != BOD_OFF) || analog_q[AN_CONV_EN] ||
		(analog_q[AN_COMP_EN] && (comp_act_d || analog_q[AN_COMP_REF]));

	// gating leaves peripheral state untouched, so clearing a bit resumes it
	generate
		for (genvar g = 0; g < NPER; g++) begin : g_pclk
			if (g == STOP_CONV) begin : g_conv
				assign pclk_d[g] = !stop_d[g] && dom_d.conv;
			end else begin : g_io
				assign pclk_d[g] = !stop_d[g] && dom_d.io;
			end
		end
	endgenerate

	always_comb begin
		ext_d = ext_q;
		ref_cnt_d = ref_cnt_q;
		ref_ready_d = ref_ready_q;
		ref_en_d = ref_need;
		if (i_conv_start) begin
			ext_d = 1'b0;
		end
		if (analog_q[AN_CONV_EN] && !analog_d[AN_CONV_EN]) begin
			ext_d = 1'b1;
		end
		// sleep does not touch the counter: a reference kept on stays ready
		if (!ref_need) begin
			ref_cnt_d = '0;
			ref_ready_d = 1'b0;
		end else if (!ref_ready_q) begin
			if (ref_cnt_q == CNT_W'(REF_START_CYC - 1)) begin
				ref_ready_d = 1'b1;
			end else begin
				ref_cnt_d = ref_cnt_q + 16'h0001;
			end
		end
	end

	// enables change at the rising edge; the latch-based gate cell only
	// follows them while its clock is low, so no gated clock can glitch
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			ext_q <= 1'b0;
			ref_cnt_q <= '0;
			ref_ready_q <= 1'b0;
			ref_en_q <= 1'b0;
			o_dom <= '{default: 1'b1};
			o_periph_clk_en <= '0;
			o_periph_access_en <= '0;
			o_comp_mux_allow <= 1'b0;
			o_comp_active <= 1'b0;
			o_conv_en <= 1'b0;
			o_bod_en <= 1'b0;
			o_wdt_run <= 1'b0;
		end else begin
			ext_q <= ext_d;
			ref_cnt_q <= ref_cnt_d;
			ref_ready_q <= ref_ready_d;
			ref_en_q <= ref_en_d;
			o_dom <= dom_d;
			o_periph_clk_en <= pclk_d;
			o_periph_access_en <= ~stop_d[NPER-1:0];
			o_comp_mux_allow <= !stop_d[STOP_CONV] && dom_d.conv;
			o_comp_active <= comp_act_d;
			o_conv_en <= analog_d[AN_CONV_EN];
			o_bod_en <= i_bod_fuses != BOD_OFF;
			o_wdt_run <= i_wdt_en;
		end
	end

	assign o_conv_extended = ext_q;
	assign o_ref_en = ref_en_q;
	assign o_ref_ready = ref_ready_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	AST_STANDBY_WAKE: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q == MODE_STANDBY)
		&& wake_hit(sleep_mode_q, i_wake) |-> ##6 !o_dom.cpu ##1 o_dom.cpu)
		else $error("standby wake not six cycles");
	AST_IDLE_HALT: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q == MODE_IDLE)
		&& |i_wake |-> ##4 !o_dom.cpu ##1 o_dom.cpu)
		else $error("idle wake halt not four cycles");
	AST_IDLE_DOM: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q == MODE_IDLE)
		|-> !o_dom.cpu && !o_dom.flash && o_dom.io && o_dom.conv && o_dom.main_src)
		else $error("idle clock domains wrong");
	AST_DEEP_DOM: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q != MODE_IDLE)
		|-> !o_dom.io && (o_dom.conv == (sleep_mode_q == MODE_NOISE))
		&& (o_dom.main_src == (sleep_mode_q != MODE_PDOWN)))
		else $error("deep clock domains wrong");
	AST_DEEP_PCLK: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q != MODE_IDLE)
		|-> !(|o_periph_clk_en[NPER-1:STOP_LIN]))
		else $error("io peripheral clocked in deep sleep");
	AST_NO_ENABLE: assert property (
		(state_q == S_ACTIVE) && i_sleep_exec && !sleep_en_q |=> state_q == S_ACTIVE)
		else $error("sleep without enable bit");
	// stop bits and enables load on one edge, so they agree every cycle
	AST_STOP_GATE: assert property (
		stop_q[STOP_CAN] |-> !o_periph_clk_en[STOP_CAN] && !o_periph_access_en[STOP_CAN])
		else $error("stopped peripheral still clocked");
	AST_RESUME: assert property (
		$fell(stop_q[STOP_TIM0]) && o_dom.io && (state_d == state_q)
		|-> o_periph_clk_en[STOP_TIM0])
		else $error("cleared stop bit did not restart clock");
	AST_RSVD_ZERO: assert property (
		!o_avs_waitrequest && $past(i_avs_address) == OFF_CLK_STOP && $past(i_avs_read)
		|-> !o_avs_readdata[7])
		else $error("reserved stop bit read as one");
	AST_COMP_MUX: assert property (stop_q[STOP_CONV] |-> !o_comp_mux_allow)
		else $error("comparator mux allowed while converter stopped");
	AST_DEEP_COMP: assert property (
		(state_q == S_SLEEP) && (sleep_mode_q == MODE_PDOWN) |-> !o_comp_active)
		else $error("comparator active in deep sleep");
	AST_WDT_BOD: assert property (
		$past(i_wdt_en) && ($past(i_bod_fuses) != BOD_OFF) |-> o_wdt_run && o_bod_en)
		else $error("watchdog or brown-out dropped");
	AST_REF_START: assert property ($rose(o_ref_en) |-> !o_ref_ready [*2])
		else $error("reference ready without start-up");
	AST_REF_NEED: assert property (
		!analog_q[AN_CONV_EN] && !analog_q[AN_COMP_EN] && (i_bod_fuses == BOD_OFF)
		|=> !o_ref_en)
		else $error("reference on with no user");
	AST_EXT_CONV: assert property ($fell(o_conv_en) |-> o_conv_extended)
		else $error("extended conversion flag not set");
	AST_CONV_KEPT: assert property (
		(state_q != S_ACTIVE) && analog_q[AN_CONV_EN] |-> o_conv_en)
		else $error("converter dropped in sleep");

	COV_STANDBY: cover property ((state_q == S_SLEEP) && (sleep_mode_q == MODE_STANDBY));
	COV_NOISE_WAKE: cover property ((state_q == S_SLEEP) && (sleep_mode_q == MODE_NOISE)
		##1 state_q == S_WAKE);
	COV_STOP_RESUME: cover property (stop_q[STOP_SPI] ##[1:20] !stop_q[STOP_SPI]);
	COV_REF_READY: cover property ($rose(o_ref_ready));
	COV_PDOWN_WAKE: cover property ((state_q == S_SLEEP) && (sleep_mode_q == MODE_PDOWN)
		##1 state_q == S_WAKE);
endmodule

//--- shared/sleep_clk_pkg.sv
// constants, types and register map of the sleep and clock-stop controller
// Contract
// - sleep code 110 with crystal selected enters standby: power-down but oscillator runs
// - wake-up from standby resumes operation after six clock cycles
// - idle stops processor and flash clocks; all wake sources usable
// - noise mode keeps converter, pll, main source; deep modes wake on level/watchdog
// - a set clock-stop bit freezes the peripheral and blocks its register access
// - clearing a clock-stop bit restarts the clock, state preserved
// - clock-stop bits matter in active and idle; deeper modes stop clocks anyway (bit 0 still gates the converter clock in noise mode)
// - top bit of clock-stop register is unused and reads zero
// - bit 6 stops the CAN controller clock
// - bit 5 stops the power-stage controller clock
// - bits 4 and 3 stop timer 1 and timer 0, which resume as before
// - bit 2 stops the SPI clock
// - bit 1 stops the LIN/UART controller clock
// - comparator cannot use converter input mux while converter clock stopped
// - converter stays enabled in sleep; first conversion after re-enable is extended
// - comparator auto-disabled in deep modes; reference kept if comparator uses it
// - fuse-enabled brown-out detector stays enabled in all sleep modes
// - enabled watchdog stays enabled and running in all sleep modes
// - reference enabled only while brown-out, comparator or converter needs it
// - reference kept on is usable at once; re-enabled reference needs start-up
// - mode codes: idle 000, noise 001, power-down 010, standby 110; rest reserved
// - sleep needs enable bit then sleep instruction; wake halts four cycles past start-up
package sleep_clk_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_CLK_STOP = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SLEEP_CTRL = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_ANALOG = 4'hc;
	localparam int NPER = 7;
	localparam int STOP_CONV = 0;
	localparam int STOP_LIN = 1;
	localparam int STOP_SPI = 2;
	localparam int STOP_TIM0 = 3;
	localparam int STOP_TIM1 = 4;
	localparam int STOP_PSC = 5;
	localparam int STOP_CAN = 6;
	localparam logic [7:0] CLK_STOP_RESET = 8'h00;
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_NOISE = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam int SLEEP_EN_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int AN_CONV_EN = 0;
	localparam int AN_COMP_EN = 1;
	localparam int AN_COMP_REF = 2;
	localparam logic [2:0] BOD_OFF = 3'h7;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] STANDBY_WAKE_CYC = 16'h0006;
	localparam logic [CNT_W-1:0] WAKE_HALT_CYC = 16'h0004;
	typedef enum logic [1:0] {S_ACTIVE, S_SLEEP, S_WAKE} state_t;
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic conv;
		logic pll;
		logic main_src;
	} clk_dom_t;
	typedef struct packed {
		logic ext_level;
		logic ext_edge;
		logic power_stage_controller;
		logic store_ready;
		logic conv;
		logic wdt;
		logic other_io;
	} wake_t;
endpackage

//--- sim/testbench.sv
// self-checking bench for the sleep and clock-stop controller
`timescale 1ns/1ns
module testbench;
	import sleep_clk_pkg::*;
	localparam int STARTUP = 4;
	localparam int REFST = 4;
	logic i_mclk, i_rst, i_avs_read, i_avs_write, i_sleep_exec, i_crystal_sel, i_wdt_en;
	logic i_conv_start, o_avs_waitrequest, o_comp_mux_allow, o_comp_active, o_conv_en;
	logic o_conv_extended, o_ref_en, o_ref_ready, o_bod_en, o_wdt_run;
	logic [ADDR_W-1:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata, seed, rd, tmp;
	logic [3:0] i_avs_byteenable;
	logic [2:0] i_bod_fuses;
	logic [7:0] v;
	wake_t i_wake;
	clk_dom_t o_dom;
	logic [NPER-1:0] o_periph_clk_en, o_periph_access_en;
	int err_total, samples_checked, n;
	int cycles = 0;

	sleep_clk_ctrl #(.STARTUP_CYC(STARTUP), .REF_START_CYC(REFST)) i_sleep_clk_ctrl (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.i_sleep_exec(i_sleep_exec), .i_wake(i_wake), .i_crystal_sel(i_crystal_sel),
		.i_bod_fuses(i_bod_fuses), .i_wdt_en(i_wdt_en), .i_conv_start(i_conv_start),
		.o_dom(o_dom), .o_periph_clk_en(o_periph_clk_en),
		.o_periph_access_en(o_periph_access_en), .o_comp_mux_allow(o_comp_mux_allow),
		.o_comp_active(o_comp_active), .o_conv_en(o_conv_en),
		.o_conv_extended(o_conv_extended), .o_ref_en(o_ref_en), .o_ref_ready(o_ref_ready),
		.o_bod_en(o_bod_en), .o_wdt_run(o_wdt_run));

	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// whole run needs well under 2000 cycles
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			results();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic clk_dom_t dom_exp(logic [2:0] m, logic x);
		case (m)
			MODE_IDLE: return 6'h0f;
			MODE_NOISE: return 6'h07;
			MODE_STANDBY: return x ? 6'h01 : 6'h00;
			default: return 6'h00;
		endcase
	endfunction

	// standby without crystal falls back to power-down timing
	function automatic int lat_exp(logic [2:0] m, logic x);
		if (m == MODE_IDLE || m == MODE_NOISE) return 4;
		if (m == MODE_STANDBY && x) return 6;
		return STARTUP + 4;
	endfunction

	// stop register holds 8'h1e in the sleep tests; io clocks die below idle
	function automatic logic [6:0] pclk_exp(logic [2:0] m);
		if (m == MODE_IDLE) return 7'h61;
		return (m == MODE_NOISE) ? 7'h01 : 7'h00;
	endfunction

	task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_dom(clk_dom_t got, clk_dom_t exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t clock domains got %b exp %b", $time, got, exp);
		end
	endtask

	// entered just after a rising edge; request held until waitrequest seen low
	task automatic bus(logic wr, logic [ADDR_W-1:0] a, logic [7:0] d);
		int k;
		k = 0;
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_writedata <= {24'h0, d};
		do begin
			@(posedge i_mclk);
			k++;
		end while (o_avs_waitrequest !== 1'b0 && k < 50);
		rd = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		if (k >= 50) chk(0, 1, "bus answer missing");
		@(posedge i_mclk);
	endtask

	task automatic rdchk(logic [ADDR_W-1:0] a, logic [31:0] exp, string what);
		bus(1'b0, a, 8'h00);
		chk(rd, exp, what);
	endtask

	task automatic settle();
		repeat (2) @(posedge i_mclk);
	endtask

	task automatic pulse_exec();
		i_sleep_exec <= 1'b1;
		@(posedge i_mclk);
		i_sleep_exec <= 1'b0;
		#1;
	endtask

	task automatic sleep_run(logic [2:0] m, logic x, wake_t bad, wake_t good);
		i_crystal_sel <= x;
		bus(1'b1, OFF_SLEEP_CTRL, {4'h0, m, 1'b1});
		pulse_exec();
		chk_dom(o_dom, dom_exp(m, x));
		i_wake <= bad;
		repeat (6) @(posedge i_mclk);
		#1;
		chk_dom(o_dom, dom_exp(m, x));
		chk(o_comp_active, (m == MODE_IDLE || m == MODE_NOISE), "comparator");
		chk(o_conv_en, 1, "converter kept");
		chk(o_wdt_run, 1, "watchdog kept");
		chk(o_bod_en, 1, "brown-out kept");
		chk(o_ref_en, 1, "reference kept");
		chk(o_periph_clk_en, pclk_exp(m), "peripheral clocks in sleep");
		chk(o_ref_ready, 1, "reference ready kept");
		i_wake <= good;
		n = 0;
		@(posedge i_mclk);
		#1;
		while (o_dom.cpu !== 1'b1 && n < 100) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		i_wake <= '0;
		chk(n, lat_exp(m, x), "wake latency");
		settle();
		chk_dom(o_dom, 6'h3f);
		$display("sleep test mode %0d crystal %0d done", m, x);
	endtask

	task automatic results();
		$display("checked %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		seed = 32'h000140fb;
		err_total = 0;
		samples_checked = 0;
		i_rst = 1'b1;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_address = '0;
		i_avs_writedata = '0;
		i_avs_byteenable = 4'hf;
		i_sleep_exec = 1'b0;
		i_wake = '0;
		i_crystal_sel = 1'b1;
		i_bod_fuses = BOD_OFF;
		i_wdt_en = 1'b0;
		i_conv_start = 1'b0;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		rdchk(OFF_CLK_STOP, 0, "stop reg reset");
		rdchk(OFF_SLEEP_CTRL, 0, "sleep ctrl reset");
		rdchk(OFF_STATUS, 0, "status reset");
		rdchk(4'h2, 0, "unmapped read");
		chk(o_periph_clk_en, 7'h7f, "clocks after reset");
		$display("reset test done");
		for (int i = 0; i < 12; i++) begin
			tmp = xs();
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : tmp[7:0];
			// converter still disabled here, so stopping its clock is legal
			bus(1'b1, OFF_CLK_STOP, v);
			rdchk(OFF_CLK_STOP, {25'h0, v[6:0]}, "stop reg");
			chk(o_periph_clk_en, 7'(~v[6:0]), "periph clocks");
			chk(o_periph_access_en, 7'(~v[6:0]), "periph access");
			chk(o_comp_mux_allow, !v[STOP_CONV], "converter mux");
		end
		i_avs_byteenable <= 4'h0;
		bus(1'b1, OFF_CLK_STOP, 8'h00);
		i_avs_byteenable <= 4'hf;
		rdchk(OFF_CLK_STOP, {25'h0, v[6:0]}, "masked write");
		bus(1'b1, OFF_CLK_STOP, 8'h00);
		chk(o_periph_clk_en, 7'h7f, "clocks restarted");
		$display("clock stop test done");
		for (int i = 0; i < 8; i++) begin
			tmp = xs();
			i_bod_fuses <= (i == 0) ? BOD_OFF : tmp[2:0];
			i_wdt_en <= tmp[3];
			bus(1'b1, OFF_ANALOG, {6'h0, tmp[5:4]});
			settle();
			chk(o_bod_en, (i_bod_fuses != BOD_OFF), "brown-out");
			chk(o_wdt_run, tmp[3], "watchdog");
			chk(o_ref_en, (i_bod_fuses != BOD_OFF) | tmp[4] | tmp[5], "reference");
		end
		i_bod_fuses <= BOD_OFF;
		bus(1'b1, OFF_ANALOG, 8'h01);
		bus(1'b1, OFF_ANALOG, 8'h00);
		settle();
		chk(o_conv_extended, 1, "extended flag");
		chk(o_ref_en, 0, "reference off");
		i_conv_start <= 1'b1;
		@(posedge i_mclk);
		i_conv_start <= 1'b0;
		settle();
		chk(o_conv_extended, 0, "extended cleared");
		bus(1'b1, OFF_ANALOG, 8'h03);
		n = 0;
		while (o_ref_ready !== 1'b1 && n < REFST + 6) begin
			@(posedge i_mclk);
			n++;
		end
		chk(o_ref_ready, 1, "reference start-up");
		$display("analog test done");
		i_wdt_en <= 1'b1;
		i_bod_fuses <= 3'h2;
		bus(1'b1, OFF_CLK_STOP, 8'h1e);
		sleep_run(MODE_IDLE, 1'b1, 7'h00, 7'h01);
		sleep_run(MODE_NOISE, 1'b1, 7'h01, 7'h08);
		sleep_run(MODE_PDOWN, 1'b1, 7'h10, 7'h40);
		sleep_run(MODE_STANDBY, 1'b1, 7'h20, 7'h02);
		sleep_run(MODE_STANDBY, 1'b0, 7'h08, 7'h40);
		bus(1'b1, OFF_SLEEP_CTRL, 8'h07);
		pulse_exec();
		settle();
		chk_dom(o_dom, 6'h3f);
		bus(1'b1, OFF_SLEEP_CTRL, 8'h00);
		pulse_exec();
		settle();
		chk_dom(o_dom, 6'h3f);
		$display("refusal test done");
		results();
	end
endmodule
